//--- verilog/grsync_regs.svh
/*
 * named constants for the global reset, enable and sync block.
 * assumes inclusion by bare name from the package; the top module has no include and relies on that.
 */
`ifndef GRSYNC_REGS_SVH
`define GRSYNC_REGS_SVH

`define GRS_NUM_CH 8
`define GRS_OFS_W 5
`define GRS_PER_W 16
`define GRS_FAULT_W 8
`define GRS_PERIOD_RST 16'h0FFF
`define GRS_OFS_DIV 32
`define GRS_ENB_OFF_RST 8'hFF
`define GRS_MASK_RST 8'h00

`endif

//--- verilog/grsync_pkg.sv
/*
 * types shared by the global reset, enable and sync block.
 * assumes grsync_regs.svh is on the include path.
 */
`include "grsync_regs.svh"

package grsync_pkg;
    typedef enum logic [1:0]
    {
        GRS_WAIT_SYNC = 2'b00,
        GRS_OFFSET = 2'b01,
        GRS_RUN = 2'b11
    } grsync_state_t;
    typedef logic [`GRS_PER_W-1:0] grsync_cnt_t;
endpackage

//--- verilog/grsync_top.sv
/*
 * global reset, enable gating, phase sync and fault alert for eight channels.
 * assumes every pin input is asynchronous to clk_sys; serial-side flags
 * and settings arrive already in the clk_sys domain.
 */
// Behaviour
// RL1 - internal power reset forces channels off, defaults
// RL2 - low reset pin holds channels off, defaults
// RL3 - enable low: per channel off or hold
// RL4 - enable behaviour defaults to all off
// RL5 - all timing derived from master clock
// RL6 - serial access only while master clock runs
// RL7 - channel edge delayed offset over 32 periods
// RL8 - sync pulse sets flag, cleared by read
// RL9 - sync rising edge restarts pwm periods
// RL10 - controller gives one sync pulse after reset
// RL11 - fault alert low for unmasked faults
// RL12 - open inputs settle to defined levels
// RL13 - reset pin falling edge sets reset flag
// RL14 - enable low flag clears after high and read
// RL15 - pins pass two-stage synchronisers first
`timescale 1ns/1ns
`default_nettype none

module grsync_top
    import grsync_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic por_active,
    input wire logic hw_reset_pin_n,
    input wire logic enable_pin,
    input wire logic sync_pin,
    input wire logic [`GRS_NUM_CH-1:0] channel_request,
    input wire logic [`GRS_NUM_CH-1:0] enable_off_cfg,
    input wire logic [`GRS_NUM_CH*`GRS_OFS_W-1:0] channel_phase_offset,
    input wire logic [`GRS_PER_W-1:0] pwm_period,
    input wire logic [`GRS_FAULT_W-1:0] fault_detected,
    input wire logic [`GRS_FAULT_W-1:0] fault_mask,
    input wire logic flag_read,
    output logic [`GRS_NUM_CH-1:0] channel_on,
    output logic [`GRS_NUM_CH-1:0] pwm_start,
    output logic block_reset,
    output logic sync_seen_flag,
    output logic reset_seen_flag,
    output logic enable_low_flag,
    output logic fault_alert_out,
    output logic fault_alert_oe
);

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [2:0] sync_s1;
    logic [2:0] sync_s2;
    logic rst_pin_q;
    logic sync_q;
    always_ff @(posedge clk_sys)
    begin
        // unconnected pins idle at reset high, enable and sync low
        if (!rst_n)
        begin
            // enable restarts at its pulled-down level, so the enable-low flag
            // also reports the two cycles the synchroniser needs to settle
            sync_s1 <= 3'h1;
            sync_s2 <= 3'h1;
            rst_pin_q <= 1'b1;
            sync_q <= 1'b0;
        end
        else
        begin
            sync_s1 <= {sync_pin, enable_pin, hw_reset_pin_n}; // RL15 RL12
            sync_s2 <= sync_s1;
            rst_pin_q <= sync_s2[0];
            sync_q <= sync_s2[2];
        end
    end
    wire logic rst_pin_n_s = sync_s2[0];
    wire logic enable_s = sync_s2[1];
    wire logic sync_s = sync_s2[2];
    wire logic sync_rise = sync_s && !sync_q; // RL9
    // internal reset: power-on (por_active, active high) or pin reset (active low)
    wire logic int_reset = por_active || !rst_pin_n_s; // RL1 RL2

    function automatic logic [`GRS_OFS_W-1:0] ofs_of(
        input int ch,
        input logic [`GRS_NUM_CH*`GRS_OFS_W-1:0] v
    );
        ofs_of = v[ch*`GRS_OFS_W +: `GRS_OFS_W];
    endfunction

    // ***************************************************
    // timebase: a 1/32-period tick derived from clk_sys
    // ***************************************************
    grsync_state_t state;
    grsync_state_t next_state;
    grsync_cnt_t sub_cnt;
    grsync_cnt_t next_sub_cnt;
    logic [`GRS_OFS_W-1:0] slot;
    logic [`GRS_OFS_W-1:0] next_slot;
    logic [`GRS_NUM_CH-1:0] next_pwm_start;
    grsync_cnt_t slot_len;
    logic tick;
    always_comb
    begin
        // slot length is the period over 32, never below one cycle  RL5 RL7
        slot_len = pwm_period / grsync_cnt_t'(`GRS_OFS_DIV);
        if (slot_len == '0)
            slot_len = grsync_cnt_t'(1);
        tick = (sub_cnt + grsync_cnt_t'(1)) >= slot_len;
        next_state = state;
        next_sub_cnt = tick ? '0 : sub_cnt + grsync_cnt_t'(1);
        next_slot = tick ? slot + 5'h01 : slot;
        next_pwm_start = '0;
        case (state)
            GRS_WAIT_SYNC:
                next_sub_cnt = '0;
            GRS_OFFSET, GRS_RUN:
            begin
                for (int c = 0; c < `GRS_NUM_CH; c++)
                    if (sub_cnt == '0 && slot == ofs_of(c, channel_phase_offset))
                        next_pwm_start[c] = 1'b1; // RL7
                // the slot counter wraps after the last slot, so each channel fires once a period
                if (tick && slot == `GRS_OFS_W'(`GRS_OFS_DIV - 1))
                    next_state = GRS_RUN;
            end
            default:
                next_state = GRS_WAIT_SYNC;
        endcase
        if (sync_rise)
        begin
            // a sync edge realigns every channel's period  RL9
            next_state = GRS_OFFSET;
            next_sub_cnt = '0;
            next_slot = '0;
            next_pwm_start = '0;
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || int_reset)
        begin
            state <= GRS_WAIT_SYNC;
            sub_cnt <= '0;
            slot <= '0;
            pwm_start <= '0;
        end
        else
        begin
            state <= next_state;
            sub_cnt <= next_sub_cnt;
            slot <= next_slot;
            pwm_start <= next_pwm_start;
        end
    end

    // ***************************************************
    // channel gating and flags
    // ***************************************************
    logic [`GRS_NUM_CH-1:0] next_channel_on;
    logic next_sync_seen;
    logic next_reset_seen;
    logic next_enable_low;
    logic next_alert;
    // enable_off_cfg lives on the serial side and leaves reset as all ones,
    // so by default every channel turns off while enable is low
    always_comb
    begin
        for (int c = 0; c < `GRS_NUM_CH; c++)
        begin
            if (enable_s)
                next_channel_on[c] = channel_request[c];
            else if (enable_off_cfg[c])
                next_channel_on[c] = 1'b0; // RL3 RL4
            else
                next_channel_on[c] = channel_on[c];
        end
        // the flag register clears as a whole on read; new events win
        next_sync_seen = sync_rise || (sync_seen_flag && !flag_read); // RL8
        // flag_read is a clk_sys strobe: a read only lands while the master clock runs
        next_reset_seen = reset_seen_flag && !flag_read; // RL13 RL6
        next_enable_low = !enable_s || (enable_low_flag && !flag_read); // RL14
        next_alert = |(fault_detected & ~fault_mask); // RL11
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            channel_on <= '0;
            sync_seen_flag <= 1'b0;
            reset_seen_flag <= 1'b0;
            enable_low_flag <= 1'b0;
            fault_alert_oe <= 1'b0;
            block_reset <= 1'b1;
        end
        else
        begin
            block_reset <= int_reset; // RL1 RL2
            fault_alert_oe <= next_alert && !int_reset; // RL11
            if (int_reset)
            begin
                channel_on <= '0; // RL1 RL2
                sync_seen_flag <= 1'b0;
                enable_low_flag <= 1'b0;
                // the reset flag survives pin reset so software can see it later
                reset_seen_flag <= reset_seen_flag || (rst_pin_q && !rst_pin_n_s); // RL13
            end
            else
            begin
                channel_on <= next_channel_on;
                sync_seen_flag <= next_sync_seen;
                reset_seen_flag <= next_reset_seen;
                enable_low_flag <= next_enable_low;
            end
        end
    end
    // open-drain pin: the data side is always low, only the enable toggles
    always_ff @(posedge clk_sys)
    begin
        fault_alert_out <= 1'b0;
    end

endmodule

`default_nettype wire

//--- verif/grs_checker.sv
/* port assertions for grsync_top.
   assumes a bind from the bench top file. */
`timescale 1ns/1ns
`default_nettype none
module grs_checker
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic por_active,
    input wire logic hw_reset_pin_n,
    input wire logic enable_pin,
    input wire logic sync_pin,
    input wire logic [7:0] enable_off_cfg,
    input wire logic [7:0] fault_detected,
    input wire logic [7:0] fault_mask,
    input wire logic flag_read,
    input wire logic [7:0] channel_on,
    input wire logic block_reset,
    input wire logic sync_seen_flag,
    input wire logic reset_seen_flag,
    input wire logic enable_low_flag,
    input wire logic fault_alert_out,
    input wire logic fault_alert_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // three samples high clears the two-stage synchroniser
    sequence sync_rise;
        !sync_pin ##1 sync_pin [*3];
    endsequence
    chk_por_reset: assert property (por_active [*4] |-> block_reset)
        else $error("por ignored");
    chk_pin_reset: assert property (!hw_reset_pin_n [*4] |-> block_reset && channel_on == 8'h00)
        else $error("pin reset ignored");
    chk_gate_off: assert property (!enable_pin [*4] |-> (channel_on & enable_off_cfg) == 8'h00)
        else $error("channel not gated");
    chk_sync_flag: assert property (disable iff (!rst_n || block_reset) sync_rise |=> sync_seen_flag)
        else $error("sync flag late");
    chk_rst_flag: assert property (!hw_reset_pin_n [*4] |-> reset_seen_flag)
        else $error("reset flag missing");
    chk_enl_set: assert property (disable iff (!rst_n || block_reset) !enable_pin [*4] |-> enable_low_flag)
        else $error("enable flag missing");
    chk_enl_keep: assert property (disable iff (!rst_n || por_active)
        hw_reset_pin_n [*4] ##0 (enable_low_flag && !flag_read) |=> enable_low_flag)
        else $error("enable flag lost");
    chk_alert_on: assert property ((|(fault_detected & ~fault_mask)) [*2] |-> fault_alert_oe)
        else $error("alert missing");
    chk_alert_off: assert property (!(|(fault_detected & ~fault_mask)) [*2] |-> !fault_alert_oe && !fault_alert_out)
        else $error("alert spurious");
endmodule
`default_nettype wire

//--- verif/grs_mcu.sv
/* controller model: one sync pulse of one link period per request.
   assumes fire is raised by the bench after reset. */
`timescale 1ns/1ns
`default_nettype none
module grs_mcu
(
    input wire logic fire,
    output logic sync_pin
);
    // idles low like the pin's pull-down; single pulses only, never a train
    initial sync_pin = 1'b0;
    always @(posedge fire)
    begin
        // non-blocking so an end of pulse that meets a clock edge is seen after it
        sync_pin <= 1'b1;
        #125;
        sync_pin <= 1'b0;
    end
endmodule
`default_nettype wire

//--- verif/global_reset_enable_sync_test.sv
/* self-checking bench for grsync_top.
   assumes grsync_pkg and grs_mcu are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module global_reset_enable_sync_test;
    logic clk_sys = 0, rst_n = 0, por_active = 0, hw_reset_pin_n = 1, enable_pin = 1;
    logic fire = 0, flag_read = 0, block_reset, sync_seen_flag, reset_seen_flag;
    logic enable_low_flag, fault_alert_out, fault_alert_oe;
    logic [7:0] channel_request = 8'hFF, enable_off_cfg = 8'h0F, fault_detected = 8'h04;
    logic [7:0] fault_mask = 8'h04, channel_on, pwm_start;
    logic [39:0] channel_phase_offset = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
    logic [15:0] pwm_period = 16'h0400;
    wire sync_pin;
    int num_errors = 0, tests_run = 0, n;
    grsync_top i_grsync_top (.clk_sys, .rst_n, .por_active, .hw_reset_pin_n, .enable_pin,
        .sync_pin, .channel_request, .enable_off_cfg, .channel_phase_offset, .pwm_period,
        .fault_detected, .fault_mask, .flag_read, .channel_on, .pwm_start, .block_reset,
        .sync_seen_flag, .reset_seen_flag, .enable_low_flag, .fault_alert_out, .fault_alert_oe);
    grs_mcu i_grs_mcu (.fire, .sync_pin);
    always #5 clk_sys = ~clk_sys;
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h got %h", s, e, g);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task rd;
        flag_read = 1;
        cyc(1);
        flag_read = 0;
        cyc(1);
    endtask
    task t_enable;
        chk("on", 8'hFF, channel_on);
        enable_pin = 0;
        cyc(5);
        chk("gated", 8'hF0, channel_on);
        rd;
        chk("enl low read", 1, enable_low_flag);
        enable_pin = 1;
        cyc(4);
        chk("enl high", 1, enable_low_flag);
        rd;
        chk("enl clear", 0, enable_low_flag);
        enable_off_cfg = 8'hFF;
        enable_pin = 0;
        cyc(5);
        chk("default off", 8'h00, channel_on);
        enable_pin = 1;
        enable_off_cfg = 8'h0F;
        cyc(4);
        chk("on again", 8'hFF, channel_on);
    endtask
    task t_reset;
        hw_reset_pin_n = 0;
        cyc(5);
        chk("pin rst", 9'h100, {block_reset, channel_on});
        chk("rst flag", 1, reset_seen_flag);
        hw_reset_pin_n = 1;
        cyc(5);
        rd;
        chk("rst flag clr", 0, reset_seen_flag);
        por_active = 1;
        cyc(5);
        chk("por", 9'h100, {block_reset, channel_on});
        por_active = 0;
        cyc(5);
    endtask
    task t_sync;
        chk("no start", 8'h00, pwm_start);
        repeat (2)
        begin
            fire = 1;
            for (n = 1; n < 20 && !pwm_start[0]; n++) cyc(1);
            fire = 0;
            chk("restart", 5, n);
            for (n = 0; n < 200 && !pwm_start[3]; n++) cyc(1);
            chk("offset", 96, n);
            chk("sync flag", 1, sync_seen_flag);
            rd;
            chk("sync clr", 0, sync_seen_flag);
        end
    endtask
    task t_fault;
        chk("masked", 0, fault_alert_oe);
        fault_mask = 8'hFB;
        cyc(3);
        chk("alert", 2'b01, {fault_alert_out, fault_alert_oe});
    endtask
    task results;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        results;
    end
    initial
    begin
        cyc(4);
        rst_n = 1;
        cyc(6);
        t_enable;
        t_reset;
        t_sync;
        t_fault;
        results;
    end
endmodule
bind grsync_top grs_checker i_grs_checker (.clk_sys, .rst_n, .por_active, .hw_reset_pin_n,
    .enable_pin, .sync_pin, .enable_off_cfg, .fault_detected, .fault_mask, .flag_read,
    .channel_on, .block_reset, .sync_seen_flag, .reset_seen_flag, .enable_low_flag,
    .fault_alert_out, .fault_alert_oe);
`default_nettype wire
